// [rtl/pll_ctrl_defs.svh]
/*
 * Register offsets, field positions, reset values and timing counts of the
 * clock control block.
 * Assumes it is included by bare name from the design modules.
 */
`ifndef PLL_CTRL_DEFS_SVH
`define PLL_CTRL_DEFS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define REG_RESTART        13'h0001
`define REG_PATH_EN        13'h0005
`define REG_BUF_FIRST      13'h000a
`define REG_BUF_LAST       13'h000e
`define REG_LOCK_TH_LO     13'h0033
`define REG_LOCK_TH_HI     13'h0034
`define REG_OSC_SEL        13'h003a
`define REG_CM_DIV         13'h0050
`define REG_CL_LOCK_TH     13'h0051
`define REG_REF_MODE       13'h0064
`define REG_STATUS         13'h007c
`define REG_RSV_TUNE       13'h00a5
`define REG_SPACE_MASK     13'h1f00

// ************************************************************
// Field positions
// ************************************************************
`define RESTART_BIT        1
`define BUF_EN_BIT         0
`define MODE_RF_SYNC_BIT   0
`define MODE_EXT_VCO_BIT   1
`define MODE_OSC_OFF_BIT   2

// ************************************************************
// Reset values
// ************************************************************
`define LOCK_TH_RST        16'h0200
`define CM_DIV_RST         8'h03
`define CL_LOCK_TH_RST     8'h10
`define BYTE_ZERO          8'h00
`define CAL_BAND_START     5'h10
`define CAL_TOP_BIT        3'h4

// ************************************************************
// Timing and framing counts
// ************************************************************
`define SYNC_IGN_GROUPS    16
`define SYNC_IGN_PER_GROUP 6
`define CAL_SETTLE_TICKS   8'h10
`define SPI_INSTR_LAST     5'h0f
`define SPI_FRAME_LAST     5'h17
`define SPI_FRAME_DONE     5'h18
`define SPI_DATA_FIRST     5'h10

`endif

// [rtl/pll_ctrl_pkg.sv]
/*
 * Types shared by the clock control block.
 * Assumes the constants header is available on the include path.
 */
package pll_ctrl_pkg;

	// ************************************************************
	// Configuration and status carriers
	// ************************************************************
	typedef struct packed {
		logic [3:0]  path_en;
		logic        rf_sync_mode;
		logic        ext_vco_mode;
		logic        osc_out_off;
		logic [1:0]  osc_sel;
		logic [15:0] lock_th;
		logic [7:0]  cm_div;
		logic [7:0]  cl_lock_th;
		logic [7:0]  rsv_tune;
	} ctrl_t;

	typedef struct packed {
		logic       sync_busy;
		logic       cal_busy;
		logic       cleanup_lock;
		logic       output_lock;
		logic [4:0] band;
	} status_t;

	typedef enum logic [2:0] {
		CAL_IDLE   = 3'b001,
		CAL_SETTLE = 3'b010,
		CAL_DECIDE = 3'b100
	} cal_state_t;

endpackage : pll_ctrl_pkg

// [rtl/reg_mem.sv]
/*
 * Small register memory holding bytes that have no dedicated logic.
 * Assumes one write port and one read port on the system clock; read data
 * appear one clock after the address.
 */
module reg_mem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input  wire logic          sys_clk_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [DW-1:0] wdata_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic      [DW-1:0] rdata_o
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge sys_clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end

endmodule : reg_mem

// [rtl/spi_reg_port.sv]
/*
 * Three-wire serial register port: 16-bit instruction (read flag, two unused
 * bits, 13-bit address) followed by one data byte, most significant bit first.
 * Assumes its pin inputs are already synchronised to the system clock.
 */
`include "pll_ctrl_defs.svh"

module spi_reg_port (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        sdio_i,
	input  wire logic [7:0]  rd_data_i,
	output logic             wr_stb_o,
	output logic             rd_stb_o,
	output logic      [12:0] addr_o,
	output logic      [7:0]  wr_data_o,
	output logic             sdio_o,
	output logic             sdio_oe_n_o
);

	logic        sclk_d;
	logic [4:0]  bit_cnt;
	logic [15:0] shift;
	logic [7:0]  out_sr;
	logic        is_rd;
	logic        loaded;
	wire         rise = sclk_i & ~sclk_d;
	wire         fall = ~sclk_i & sclk_d;
	wire         take = rise && (bit_cnt != `SPI_FRAME_DONE);

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			sclk_d      <= 1'b0;
			bit_cnt     <= 5'h00;
			shift       <= 16'h0000;
			out_sr      <= 8'h00;
			is_rd       <= 1'b0;
			loaded      <= 1'b0;
			wr_stb_o    <= 1'b0;
			rd_stb_o    <= 1'b0;
			addr_o      <= 13'h0000;
			wr_data_o   <= 8'h00;
			sdio_o      <= 1'b0;
			sdio_oe_n_o <= 1'b1;
		end else begin
			sclk_d   <= sclk_i;
			wr_stb_o <= 1'b0;
			rd_stb_o <= 1'b0;
			if (cs_n_i) begin
				bit_cnt     <= 5'h00;
				is_rd       <= 1'b0;
				loaded      <= 1'b0;
				sdio_oe_n_o <= 1'b1;
			end else begin
				if (take) begin
					shift   <= {shift[14:0], sdio_i};
					bit_cnt <= bit_cnt + 5'h01;
					if (bit_cnt == `SPI_INSTR_LAST) begin
						addr_o   <= {shift[11:0], sdio_i};
						is_rd    <= shift[14];
						rd_stb_o <= shift[14];
					end
					if (bit_cnt == `SPI_FRAME_LAST && !is_rd) begin
						wr_data_o <= {shift[6:0], sdio_i};
						wr_stb_o  <= 1'b1;
					end
				end
				// Data are launched on falling edges so the master samples them
				// half a clock later on the rising edge.
				if (fall && is_rd && bit_cnt >= `SPI_DATA_FIRST) begin
					if (!loaded) begin
						sdio_o      <= rd_data_i[7];
						out_sr      <= {rd_data_i[6:0], 1'b0};
						loaded      <= 1'b1;
						sdio_oe_n_o <= 1'b0;
					end else begin
						sdio_o <= out_sr[7];
						out_sr <= {out_sr[6:0], 1'b0};
					end
				end
			end
		end
	end

endmodule : spi_reg_port

// [rtl/pll_config_lock_sync_control.sv]
/*
 * Digital control of a dual-loop jitter attenuator: reference routing, the
 * common-multiple clock and cleanup-loop lock timer, output-loop lock
 * detection, oscillator core selection, band calibration and the external
 * sync input that re-phases the system-reference timer.
 * Assumes sys_clk_i is the crystal-oscillator clock and every other input
 * arrives asynchronously from pins or analog comparators.
 */
//
// Behaviour
// - Separate buffer enables for four references and the crystal input.
// - Four-bit field admits each reference as a cleanup-loop candidate.
// - Sync mode bit zero keeps reference zero a plain reference clock.
// - External oscillator bit zero keeps reference one off the oscillator path.
// - Oscillator-output control bit one stops driving reference two pins.
// - Cleanup-loop logic and timers run in common-multiple clock periods.
// - Output-loop lock after consecutive low-error cycles reach threshold, default 512.
// - Toggling the restart bit starts automatic band calibration.
// - Calibration picks one of 32 bands, keeping tuning margin.
// - Sync pin sampled on crystal clock; rising edge re-phases reference timer.
// - After a sync edge the pin is ignored for 16 times 6 periods.
//
`include "pll_ctrl_defs.svh"

module pll_config_lock_sync_control #(
	parameter int NREF = 4
) (
	input  wire logic            sys_clk_i,
	input  wire logic            rst_n_i,
	input  wire logic            spi_sclk_i,
	input  wire logic            spi_cs_n_i,
	input  wire logic            spi_sdio_i,
	output logic                 spi_sdio_o,
	output logic                 spi_sdio_oe_n_o,
	input  wire logic            sync_pin_i,
	input  wire logic            pd2_cmp_i,
	input  wire logic            pd2_low_err_i,
	input  wire logic            pd1_low_err_i,
	input  wire logic            tune_high_i,
	output logic      [NREF:0]   ref_buf_en_o,
	output logic      [NREF-1:0] ref_path_active_o,
	output logic                 ref0_rf_sync_o,
	output logic                 ref1_ext_vco_o,
	output logic                 osc_out_drive_o,
	output logic      [1:0]      osc_core_en_o,
	output logic      [4:0]      vco_band_o,
	output logic                 band_cal_busy_o,
	output logic                 div_restart_o,
	output logic                 output_loop_lock_o,
	output logic                 cleanup_loop_lock_o,
	output logic                 cm_clk_o,
	output logic                 sysref_rephase_o,
	output logic      [7:0]      rsv_tune_o
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	localparam int NSYNC = 8;
	wire  [NSYNC-1:0] pin_raw = {spi_sdio_i, spi_cs_n_i, spi_sclk_i, tune_high_i,
	                             pd1_low_err_i, pd2_low_err_i, pd2_cmp_i, sync_pin_i};
	logic [NSYNC-1:0] pin_meta;
	logic [NSYNC-1:0] pin_s;

	genvar g;
	generate
		for (g = 0; g < NSYNC; g++) begin : g_sync
			always_ff @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					pin_meta[g] <= 1'b0;
					pin_s[g]    <= 1'b0;
				end else begin
					pin_meta[g] <= pin_raw[g];
					pin_s[g]    <= pin_meta[g];
				end
			end
		end
	endgenerate

	wire sync_s    = pin_s[0];
	wire cmp_s     = pin_s[1];
	wire low2_s    = pin_s[2];
	wire low1_s    = pin_s[3];
	wire tune_hi_s = pin_s[4];

	logic sync_d;
	logic cmp_d;
	wire  sync_edge = sync_s & ~sync_d;
	wire  cmp_tick  = cmp_s & ~cmp_d;

	// ************************************************************
	// Register port and decode
	// ************************************************************
	logic        wr_stb;
	logic [12:0] addr;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data;
	logic [7:0]  mem_q;

	spi_reg_port u_spi (
		.sys_clk_i   (sys_clk_i),
		.rst_n_i     (rst_n_i),
		.sclk_i      (pin_s[5]),
		.cs_n_i      (pin_s[6]),
		.sdio_i      (pin_s[7]),
		.rd_data_i   (rd_data),
		.wr_stb_o    (wr_stb),
		.rd_stb_o    (),
		.addr_o      (addr),
		.wr_data_o   (wr_data),
		.sdio_o      (spi_sdio_o),
		.sdio_oe_n_o (spi_sdio_oe_n_o)
	);

	wire in_space = (addr & `REG_SPACE_MASK) == 13'h0000;

	reg_mem #(
		.AW (8),
		.DW (8)
	) u_mem (
		.sys_clk_i (sys_clk_i),
		.we_i      (wr_stb && in_space),
		.waddr_i   (addr[7:0]),
		.wdata_i   (wr_data),
		.raddr_i   (addr[7:0]),
		.rdata_o   (mem_q)
	);

	pll_ctrl_pkg::ctrl_t   ctrl;
	pll_ctrl_pkg::status_t stat;
	logic [7:0]            restart_reg;
	logic [7:0]            buf_reg [0:NREF];

	wire hit_restart = wr_stb && addr == `REG_RESTART;
	wire hit_path    = wr_stb && addr == `REG_PATH_EN;
	wire hit_th_lo   = wr_stb && addr == `REG_LOCK_TH_LO;
	wire hit_th_hi   = wr_stb && addr == `REG_LOCK_TH_HI;
	wire hit_osc     = wr_stb && addr == `REG_OSC_SEL;
	wire hit_cm_div  = wr_stb && addr == `REG_CM_DIV;
	wire hit_cl_th   = wr_stb && addr == `REG_CL_LOCK_TH;
	wire hit_mode    = wr_stb && addr == `REG_REF_MODE;
	wire hit_rsv     = wr_stb && addr == `REG_RSV_TUNE;

	// A restart request is a one followed by a zero in the restart bit.
	wire restart_toggle = hit_restart && restart_reg[`RESTART_BIT]
	                      && !wr_data[`RESTART_BIT];

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			restart_reg     <= `BYTE_ZERO;
			ctrl.path_en    <= 4'h0;
			ctrl.rf_sync_mode <= 1'b0;
			ctrl.ext_vco_mode <= 1'b0;
			ctrl.osc_out_off  <= 1'b0;
			ctrl.osc_sel    <= 2'h0;
			ctrl.lock_th    <= `LOCK_TH_RST;
			ctrl.cm_div     <= `CM_DIV_RST;
			ctrl.cl_lock_th <= `CL_LOCK_TH_RST;
			ctrl.rsv_tune   <= `BYTE_ZERO;
		end else begin
			if (hit_restart) restart_reg <= wr_data;
			if (hit_path)    ctrl.path_en <= wr_data[3:0];
			if (hit_th_lo)   ctrl.lock_th[7:0] <= wr_data;
			if (hit_th_hi)   ctrl.lock_th[15:8] <= wr_data;
			if (hit_osc)     ctrl.osc_sel <= wr_data[1:0];
			if (hit_cm_div)  ctrl.cm_div <= wr_data;
			if (hit_cl_th)   ctrl.cl_lock_th <= wr_data;
			if (hit_rsv)     ctrl.rsv_tune <= wr_data;
			if (hit_mode) begin
				ctrl.rf_sync_mode <= wr_data[`MODE_RF_SYNC_BIT];
				ctrl.ext_vco_mode <= wr_data[`MODE_EXT_VCO_BIT];
				ctrl.osc_out_off  <= wr_data[`MODE_OSC_OFF_BIT];
			end
		end
	end

	generate
		for (g = 0; g <= NREF; g++) begin : g_buf
			always_ff @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					buf_reg[g] <= `BYTE_ZERO;
				end else if (wr_stb && addr == `REG_BUF_FIRST + 13'(g)) begin
					buf_reg[g] <= wr_data;
				end
			end
		end
	endgenerate

	wire [7:0] mode_byte = {5'h00, ctrl.osc_out_off, ctrl.ext_vco_mode, ctrl.rf_sync_mode};

	always_comb begin
		if (!in_space) begin
			rd_data = `BYTE_ZERO;
		end else if (addr == `REG_RESTART) begin
			rd_data = restart_reg;
		end else if (addr >= `REG_BUF_FIRST && addr <= `REG_BUF_LAST) begin
			rd_data = buf_reg[3'(addr - `REG_BUF_FIRST)];
		end else if (addr == `REG_PATH_EN) begin
			rd_data = {4'h0, ctrl.path_en};
		end else if (addr == `REG_LOCK_TH_LO) begin
			rd_data = ctrl.lock_th[7:0];
		end else if (addr == `REG_LOCK_TH_HI) begin
			rd_data = ctrl.lock_th[15:8];
		end else if (addr == `REG_OSC_SEL) begin
			rd_data = {6'h00, ctrl.osc_sel};
		end else if (addr == `REG_CM_DIV) begin
			rd_data = ctrl.cm_div;
		end else if (addr == `REG_CL_LOCK_TH) begin
			rd_data = ctrl.cl_lock_th;
		end else if (addr == `REG_REF_MODE) begin
			rd_data = mode_byte;
		end else if (addr == `REG_STATUS) begin
			rd_data = {stat.sync_busy, stat.cal_busy, stat.cleanup_lock,
			           stat.output_lock, 4'h0} | {3'h0, stat.band};
		end else if (addr == `REG_RSV_TUNE) begin
			rd_data = ctrl.rsv_tune;
		end else begin
			rd_data = mem_q;
		end
	end

	// ************************************************************
	// Reference routing
	// ************************************************************
	function automatic logic [1:0] core_decode(input logic [1:0] sel);
		core_decode = (sel == 2'h1) ? 2'b01 : (sel == 2'h2) ? 2'b10 : 2'b00;
	endfunction : core_decode

	logic [NREF:0] buf_bits;
	generate
		for (g = 0; g <= NREF; g++) begin : g_bits
			assign buf_bits[g] = buf_reg[g][`BUF_EN_BIT];
		end
	endgenerate

	// A reference is a cleanup-loop candidate only when buffered, admitted and
	// not taken over by its alternate function.
	wire            osc_drive  = !ctrl.osc_out_off && buf_bits[NREF];
	wire [NREF-1:0] ref_taken  = {{(NREF-3){1'b0}}, osc_drive, ctrl.ext_vco_mode,
	                              ctrl.rf_sync_mode};
	wire [NREF-1:0] next_paths = buf_bits[NREF-1:0] & ctrl.path_en & ~ref_taken;

	// ************************************************************
	// Common-multiple clock and cleanup-loop lock timer
	// ************************************************************
	logic [7:0] cm_cnt;
	logic [7:0] cl_cnt;
	wire        cm_tick = (cm_cnt == ctrl.cm_div) && !cm_clk_o;

	// ************************************************************
	// Output-loop lock, sync and calibration state
	// ************************************************************
	localparam logic [7:0] SYNC_IGN = 8'(`SYNC_IGN_GROUPS * `SYNC_IGN_PER_GROUP);
	logic [15:0]              lock_cnt;
	logic [7:0]               ign_cnt;
	logic [7:0]               settle_cnt;
	logic [2:0]               cal_bit;
	pll_ctrl_pkg::cal_state_t cal_st;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			sync_d   <= 1'b0;
			cmp_d    <= 1'b0;
			lock_cnt <= 16'h0000;
			ign_cnt  <= 8'h00;
			cm_cnt   <= 8'h00;
			cl_cnt   <= 8'h00;
		end else begin
			sync_d <= sync_s;
			cmp_d  <= cmp_s;
			if (restart_toggle || !low2_s && cmp_tick) begin
				lock_cnt <= 16'h0000;
			end else if (cmp_tick && lock_cnt != ctrl.lock_th) begin
				lock_cnt <= lock_cnt + 16'h0001;
			end
			if (sync_edge && ign_cnt == 8'h00) begin
				ign_cnt <= SYNC_IGN;
			end else if (cmp_tick && ign_cnt != 8'h00) begin
				ign_cnt <= ign_cnt - 8'h01;
			end
			cm_cnt <= (cm_cnt == ctrl.cm_div) ? 8'h00 : cm_cnt + 8'h01;
			if (cm_tick) begin
				if (!low1_s) begin
					cl_cnt <= 8'h00;
				end else if (cl_cnt != ctrl.cl_lock_th) begin
					cl_cnt <= cl_cnt + 8'h01;
				end
			end
		end
	end

	// Successive approximation from the top band bit; a band that still needs
	// a high tuning voltage is too low and keeps its bit, which leaves the
	// result centred in the tuning range for temperature drift.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			cal_st     <= pll_ctrl_pkg::CAL_IDLE;
			cal_bit    <= 3'h0;
			settle_cnt <= 8'h00;
			vco_band_o <= `CAL_BAND_START;
		end else begin
			case (cal_st)
				pll_ctrl_pkg::CAL_IDLE: begin
					if (restart_toggle) begin
						vco_band_o <= `CAL_BAND_START;
						cal_bit    <= `CAL_TOP_BIT;
						settle_cnt <= `CAL_SETTLE_TICKS;
						cal_st     <= pll_ctrl_pkg::CAL_SETTLE;
					end
				end
				pll_ctrl_pkg::CAL_SETTLE: begin
					if (settle_cnt == 8'h00) begin
						cal_st <= pll_ctrl_pkg::CAL_DECIDE;
					end else if (cmp_tick) begin
						settle_cnt <= settle_cnt - 8'h01;
					end
				end
				pll_ctrl_pkg::CAL_DECIDE: begin
					if (!tune_hi_s) begin
						vco_band_o[cal_bit] <= 1'b0;
					end
					if (cal_bit == 3'h0) begin
						cal_st <= pll_ctrl_pkg::CAL_IDLE;
					end else begin
						vco_band_o[cal_bit - 3'h1] <= 1'b1;
						cal_bit    <= cal_bit - 3'h1;
						settle_cnt <= `CAL_SETTLE_TICKS;
						cal_st     <= pll_ctrl_pkg::CAL_SETTLE;
					end
				end
				default: begin
					cal_st <= pll_ctrl_pkg::CAL_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ref_buf_en_o        <= '0;
			ref_path_active_o   <= '0;
			ref0_rf_sync_o      <= 1'b0;
			ref1_ext_vco_o      <= 1'b0;
			osc_out_drive_o     <= 1'b0;
			osc_core_en_o       <= 2'h0;
			band_cal_busy_o     <= 1'b0;
			div_restart_o       <= 1'b0;
			output_loop_lock_o  <= 1'b0;
			cleanup_loop_lock_o <= 1'b0;
			cm_clk_o            <= 1'b0;
			sysref_rephase_o    <= 1'b0;
			rsv_tune_o          <= `BYTE_ZERO;
		end else begin
			ref_buf_en_o        <= buf_bits;
			ref_path_active_o   <= next_paths;
			ref0_rf_sync_o      <= ctrl.rf_sync_mode;
			ref1_ext_vco_o      <= ctrl.ext_vco_mode;
			osc_out_drive_o     <= osc_drive;
			osc_core_en_o       <= core_decode(ctrl.osc_sel);
			band_cal_busy_o     <= cal_st != pll_ctrl_pkg::CAL_IDLE;
			div_restart_o       <= restart_toggle;
			output_loop_lock_o  <= lock_cnt == ctrl.lock_th && !restart_toggle;
			cleanup_loop_lock_o <= cl_cnt == ctrl.cl_lock_th;
			if (cm_cnt == ctrl.cm_div) cm_clk_o <= !cm_clk_o;
			sysref_rephase_o    <= sync_edge && ign_cnt == 8'h00;
			rsv_tune_o          <= ctrl.rsv_tune;
		end
	end

	assign stat.sync_busy    = ign_cnt != 8'h00;
	assign stat.cal_busy     = band_cal_busy_o;
	assign stat.cleanup_lock = cleanup_loop_lock_o;
	assign stat.output_lock  = output_loop_lock_o;
	assign stat.band         = vco_band_o;

endmodule : pll_config_lock_sync_control

// [verif/pll_ctrl_monitor.sv]
/* Concurrent checks on the ports of the clock control block.
 * Assumes the common-multiple divider keeps its reset value of 3.
 */
module pll_ctrl_monitor (
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	input wire logic       pd2_cmp_i,
	input wire logic       pd2_low_err_i,
	input wire logic       sync_pin_i,
	input wire logic [4:0] ref_buf_en_o,
	input wire logic [3:0] ref_path_active_o,
	input wire logic       osc_out_drive_o,
	input wire logic [4:0] vco_band_o,
	input wire logic       band_cal_busy_o,
	input wire logic       div_restart_o,
	input wire logic       output_loop_lock_o,
	input wire logic       cm_clk_o,
	input wire logic       sysref_rephase_o
);
	logic       pd2_q;
	logic [6:0] gap;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// The gap count saturates, so a long quiet spell never wraps into a false refusal.
	always_ff @(posedge sys_clk_i) begin
		pd2_q <= pd2_cmp_i;
		if (!rst_n_i)
			gap <= 7'h7f;
		else if (sysref_rephase_o)
			gap <= 7'h00;
		else if (pd2_cmp_i && !pd2_q && gap != 7'h7f)
			gap <= gap + 7'h01;
	end
	// ****
	// Properties
	// ****
	sequence s_bad_edge;
		pd2_cmp_i && !pd2_q && !pd2_low_err_i;
	endsequence
	sequence s_cm_hold;
		$stable(cm_clk_o) [*3];
	endsequence
	property p_restart;
		div_restart_o |-> ##[0:3] band_cal_busy_o;
	endproperty
	property p_band_hold;
		!band_cal_busy_o && !div_restart_o |-> $stable(vco_band_o);
	endproperty
	property p_lock_drop;
		s_bad_edge |-> ##[1:6] !output_loop_lock_o;
	endproperty
	property p_sync_pulse;
		sysref_rephase_o |-> $past(sync_pin_i, 2) ##1 !sysref_rephase_o;
	endproperty
	property p_sync_ignore;
		sysref_rephase_o |-> gap >= 7'h5e;
	endproperty
	property p_cm_clk;
		$changed(cm_clk_o) |=> s_cm_hold;
	endproperty
	property p_path;
		(ref_path_active_o & ~ref_buf_en_o[3:0] & ~$past(ref_buf_en_o[3:0])) == 4'h0;
	endproperty
	property p_osc_out;
		osc_out_drive_o |-> ref_buf_en_o[4] || $past(ref_buf_en_o[4]);
	endproperty
	a_restart: assert property (p_restart)
		else $error("calibration did not start");
	a_band_hold: assert property (p_band_hold)
		else $error("band moved while idle");
	a_lock_drop: assert property (p_lock_drop)
		else $error("lock kept after error");
	a_sync_pulse: assert property (p_sync_pulse)
		else $error("bad re-phase pulse");
	a_sync_ignore: assert property (p_sync_ignore)
		else $error("sync taken too soon");
	a_cm_clk: assert property (p_cm_clk)
		else $error("bad cm clock period");
	a_path: assert property (p_path)
		else $error("path without buffer");
	a_osc_out: assert property (p_osc_out)
		else $error("osc drive without buffer");
endmodule : pll_ctrl_monitor

// [verif/spi_host_model.sv]
/* Host model: serial register master and external sync source.
 * Assumes the bench resolves the shared data wire and feeds it back.
 */
module spi_host_model (
	input  wire logic sys_clk_i,
	input  wire logic sdio_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdio_o,
	output logic      sync_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdio_o = 1'b0;
		sync_o = 1'b0;
	end
	// While the device answers, the host toggles its own drive so stale data never passes.
	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [23:0] f;
		f = {rd, 2'b00, a, d};
		@(negedge sys_clk_i) cs_n_o = 1'b0;
		repeat (4) @(negedge sys_clk_i);
		for (int i = 23; i >= 0; i--) begin
			sclk_o = 1'b0;
			sdio_o = (rd && i < 8) ? ~sdio_o : f[i];
			repeat (4) @(negedge sys_clk_i);
			q = {q[6:0], sdio_i};
			sclk_o = 1'b1;
			repeat (4) @(negedge sys_clk_i);
		end
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdio_o = ~sdio_o;
		repeat (8) @(negedge sys_clk_i);
	endtask : xfer
	task automatic sync_edge(input int hi);
		@(negedge sys_clk_i) sync_o = 1'b1;
		repeat (hi) @(negedge sys_clk_i);
		sync_o = 1'b0;
	endtask : sync_edge
endmodule : spi_host_model

// [verif/tb_top.sv]
/* Self-checking bench of the clock control block.
 * Assumes the design, the host model and the checker are compiled first.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, pd2, pd2_ok, pd1_ok, tune, sclk, cs_n, h_sd, d_sd, oe_n, sync;
	logic        rfs, extv, oscd, busy, restart, olock, cl_lock, cmc, reph;
	logic [4:0]  buf_en, band, b;
	logic [3:0]  path, pe;
	logic [1:0]  core;
	logic [7:0]  rsv, q;
	logic [15:0] s;
	int          bad_count, n_checks, n_reph, n_rst;
	wire         sdio_w = oe_n ? h_sd : d_sd;
	always #5 clk = ~clk;
	always #30 pd2 = ~pd2;
	always @(posedge clk) begin
		if (reph === 1'b1) n_reph++;
		if (restart === 1'b1) n_rst++;
	end
	spi_host_model host_u (.sys_clk_i(clk), .sdio_i(sdio_w), .sclk_o(sclk), .cs_n_o(cs_n),
		.sdio_o(h_sd), .sync_o(sync));
	pll_config_lock_sync_control dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .spi_sclk_i(sclk),
		.spi_cs_n_i(cs_n), .spi_sdio_i(sdio_w), .spi_sdio_o(d_sd), .spi_sdio_oe_n_o(oe_n),
		.sync_pin_i(sync), .pd2_cmp_i(pd2), .pd2_low_err_i(pd2_ok), .pd1_low_err_i(pd1_ok),
		.tune_high_i(tune), .ref_buf_en_o(buf_en), .ref_path_active_o(path),
		.ref0_rf_sync_o(rfs), .ref1_ext_vco_o(extv), .osc_out_drive_o(oscd),
		.osc_core_en_o(core), .vco_band_o(band), .band_cal_busy_o(busy),
		.div_restart_o(restart), .output_loop_lock_o(olock), .cleanup_loop_lock_o(cl_lock),
		.cm_clk_o(cmc), .sysref_rephase_o(reph), .rsv_tune_o(rsv));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	function automatic logic [3:0] f_path(input logic [4:0] bb, input logic [3:0] p,
		input logic [2:0] m);
		return bb[3:0] & p & ~{1'b0, bb[4] & ~m[2], m[1], m[0]};
	endfunction : f_path
	function automatic logic [1:0] f_core(input logic [1:0] v);
		return (v == 2'h1 || v == 2'h2) ? v : 2'h0;
	endfunction : f_core
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		host_u.xfer(1'b0, a, d, q);
	endtask : wr
	task automatic rdc(input string nm, input logic [12:0] a, input logic [7:0] e);
		host_u.xfer(1'b1, a, 8'h00, q);
		chk(nm, 16'(e), 16'(q));
	endtask : rdc
	// Ends five clocks after a comparison edge, before the next one can land.
	task automatic edges(input int n);
		repeat (n) @(posedge pd2);
		repeat (5) @(negedge clk);
	endtask : edges
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	initial begin
		{clk, pd2, rst_n, pd2_ok, pd1_ok, tune} = 6'h00;
		{bad_count, n_checks, n_reph, n_rst} = '0;
		s = 16'hbe5a;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		chk("band", 16'h0010, 16'(band));
		chk("rsv", 16'h0000, 16'(rsv));
		rdc("th_hi", 13'h0034, 8'h02);
		for (int i = 0; i < 5; i++) begin
			s = lfsr(s);
			b[i] = s[0];
			wr(13'(13'h000a + i), s[7:0]);
		end
		chk("buf", 16'(b), 16'(buf_en));
		rdc("buf_rd", 13'h000e, s[7:0]);
		s = lfsr(s);
		pe = s[3:0];
		wr(13'h0005, {4'h0, pe});
		for (int m = 0; m < 8; m++) begin
			wr(13'h0064, 8'(m));
			chk("rf_sync", 16'(m[0]), 16'(rfs));
			chk("ext_vco", 16'(m[1]), 16'(extv));
			chk("osc_drv", 16'(b[4] & ~m[2]), 16'(oscd));
			chk("path", 16'(f_path(b, pe, m[2:0])), 16'(path));
		end
		wr(13'h00a5, 8'h06);
		wr(13'h01a5, 8'hff);
		chk("rsv", 16'h0006, 16'(rsv));
		rdc("unmapped", 13'h01a5, 8'h00);
		for (int v = 0; v < 4; v++) begin
			wr(13'h003a, 8'(v));
			chk("core", 16'(f_core(v[1:0])), 16'(core));
		end
		$display("config test done");
		wr(13'h0033, 8'h08);
		wr(13'h0034, 8'h00);
		edges(2);
		pd2_ok = 1'b1;
		edges(7);
		chk("lock7", 16'h0000, 16'(olock));
		edges(1);
		chk("lock8", 16'h0001, 16'(olock));
		pd2_ok = 1'b0;
		edges(1);
		chk("lock_err", 16'h0000, 16'(olock));
		pd2_ok = 1'b1;
		edges(7);
		chk("relock7", 16'h0000, 16'(olock));
		edges(1);
		chk("relock8", 16'h0001, 16'(olock));
		wr(13'h0051, 8'h0c);
		pd1_ok = 1'b1;
		repeat (20) @(negedge clk);
		chk("cl_early", 16'h0000, 16'(cl_lock));
		repeat (200) @(negedge clk);
		chk("cl_lock", 16'h0001, 16'(cl_lock));
		$display("lock test done");
		host_u.sync_edge(10);
		repeat (10) @(negedge clk);
		chk("sync1", 16'h0001, 16'(n_reph));
		host_u.sync_edge(10);
		repeat (200) @(negedge clk);
		chk("sync_ign", 16'h0001, 16'(n_reph));
		repeat (96) @(posedge pd2);
		host_u.sync_edge(10);
		repeat (10) @(negedge clk);
		chk("sync2", 16'h0002, 16'(n_reph));
		$display("sync test done");
		for (int t = 1; t >= 0; t--) begin
			tune = t[0];
			wr(13'h0001, 8'h02);
			wr(13'h0001, 8'h00);
			chk("busy", 16'h0001, 16'(busy));
			for (int w = 0; w < 2000 && busy !== 1'b0; w++) @(negedge clk);
			chk("cal_band", t ? 16'h001f : 16'h0000, 16'(band));
		end
		chk("restarts", 16'h0002, 16'(n_rst));
		rdc("status", 13'h007c, 8'h30);
		$display("calibration test done");
		results;
	end
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		results;
	end
endmodule : tb_top
bind pll_config_lock_sync_control pll_ctrl_monitor mon_u (.*);
